// ===== include/bgsf_pkg.sv
// Package for the gas gauge status and identity register set.
// Assumes one 100 MHz clock and a command port decoded by the serial front end.
package bgsf_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0]  CMD_UNCERTAINTY   = 8'h0C;
  localparam logic [7:0]  CMD_STATUS        = 8'h16;
  localparam logic [7:0]  CMD_CHEM_STRING   = 8'h22;
  localparam logic [7:0]  CMD_MAKER_DATA    = 8'h23;
  localparam logic [7:0]  CMD_STATUS_WORD   = 8'h2F;
  localparam logic [7:0]  CMD_FIRST_CUTOFF  = 8'h3E;
  localparam logic [7:0]  CMD_FINAL_CUTOFF  = 8'h3F;
  localparam logic [7:0]  CMD_RESET_TRIGGER = 8'h44;

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [15:0] RESET_KEY         = 16'h1F49;
  localparam logic [15:0] UNCERT_BLOCKED    = 16'h0002;
  localparam logic [15:0] UNCERT_RESET      = 16'h0064;
  localparam logic [3:0]  ERR_OK            = 4'h0;
  localparam logic [3:0]  ERR_UNSUPPORTED   = 4'h3;
  localparam logic [3:0]  ERR_ACCESS_DENIED = 4'h4;
  localparam int          STR_BYTES         = 16;
  localparam logic [3:0]  STR_MAX_INDEX     = 4'hF;

  // ************************************************************
  // Upper and lower status byte bit positions
  // ************************************************************
  localparam int UB_DISPLAY   = 7;
  localparam int UB_CHEM      = 5;
  localparam int UB_CC        = 4;
  localparam int UB_HIGH_V    = 2;
  localparam int UB_COLD      = 1;
  localparam int UB_OVERCUR   = 0;
  localparam int LB_VQ        = 5;
  localparam int LB_LOCK      = 4;
  localparam int LB_LEARN     = 3;
  localparam int LB_DRAIN     = 2;
  localparam int LB_FIRST     = 1;
  localparam int LB_FINAL     = 0;
  localparam int UB_RSVD_HI   = 6;
  localparam int UB_RSVD_LO   = 3;
  localparam int LB_RSVD_HI   = 7;
  localparam int LB_RSVD_LO   = 6;

  // Comparator results from the analog and capacity logic
  typedef struct packed {
    logic v_high;
    logic v_low;
    logic temp_below0;
    logic temp_above5;
    logic cur_over;
    logic cur_below256;
    logic charge_sense;
    logic charge_10mah;
    logic discharging;
    logic drain_over;
    logic drain_under;
    logic below_first;
    logic above_first;
    logic below_final;
    logic above_final;
    logic partial_charge;
    logic self_dis_over;
    logic learn_start;
    logic valid_term;
  } bgsf_meas_t;

  // Defaults read from the configuration EEPROM
  typedef struct packed {
    logic [127:0] chem_str;
    logic [127:0] maker_data;
    logic [15:0]  first_cutoff;
    logic [15:0]  final_cutoff;
    logic         display_select;
    logic         chemistry_select;
    logic         charge_termination_preset;
    logic         write_lock_bit;
  } bgsf_cfg_t;

  // Decoded command from the serial front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [3:0]  index;
    logic [15:0] wdata;
  } bgsf_cmd_t;

endpackage : bgsf_pkg

// ===== hdl/bgsf_top.sv
// Status flags, identity strings and software reset of the gas gauge.
// Assumes measurement comparators on the same clock and EEPROM defaults via cfg_load_i.
`timescale 1ns/1ps

module bgsf_top
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire bgsf_pkg::bgsf_cmd_t  cmd_i,
  input  wire bgsf_pkg::bgsf_meas_t meas_i,
  input  wire bgsf_pkg::bgsf_cfg_t  cfg_i,
  input  wire logic                 cfg_load_i,
  output logic                      rsp_valid_o,
  output logic [15:0]               rsp_data_o,
  output logic [3:0]                err_code_o,
  output logic [15:0]               status_word_o,
  output logic                      display_select_o,
  output logic                      rm_load_o,
  output logic                      sw_reset_o
);

  logic [7:0]          upper_r;
  logic [7:0]          lower_r;
  logic [15:0]         first_cutoff_r;
  logic [15:0]         final_cutoff_r;
  logic [127:0]        chem_str_r;
  logic [127:0]        maker_r;
  logic [15:0]         uncert_r;
  logic [3:0]          err_r;
  logic [15:0]         rsp_data_r;
  logic                rsp_valid_r;
  logic                rm_load_r;
  logic                sw_reset_r;
  logic [15:0]         rsp_data_nxt;
  logic [7:0]          str_byte [bgsf_pkg::STR_BYTES];
  logic [7:0]          mak_byte [bgsf_pkg::STR_BYTES];
  logic                wr_req;
  logic                rd_req;
  logic                wr_ok;
  logic                reset_hit;

  // ************************************************************
  // Command decode
  // ************************************************************
  assign rd_req    = cmd_i.valid && !cmd_i.write;
  assign wr_req    = cmd_i.valid && cmd_i.write;
  assign wr_ok     = wr_req && !lower_r[bgsf_pkg::LB_LOCK];
  assign reset_hit = wr_ok && cmd_i.code == bgsf_pkg::CMD_RESET_TRIGGER
                     && cmd_i.wdata == bgsf_pkg::RESET_KEY
                     && uncert_r != bgsf_pkg::UNCERT_BLOCKED;

  // Byte lanes of the two string registers
  genvar gi;
  generate
    for (gi = 0; gi < bgsf_pkg::STR_BYTES; gi++)
    begin : g_bytes
      assign str_byte[gi] = chem_str_r[gi*8 +: 8];
      assign mak_byte[gi] = maker_r[gi*8 +: 8];
    end
  endgenerate

  always_comb
  begin
    rsp_data_nxt = 16'h0000;
    case (cmd_i.code)
      bgsf_pkg::CMD_CHEM_STRING:  rsp_data_nxt = {8'h00, str_byte[cmd_i.index]};
      bgsf_pkg::CMD_MAKER_DATA:   rsp_data_nxt = {8'h00, mak_byte[cmd_i.index]};
      bgsf_pkg::CMD_FIRST_CUTOFF: rsp_data_nxt = first_cutoff_r;
      bgsf_pkg::CMD_FINAL_CUTOFF: rsp_data_nxt = final_cutoff_r;
      bgsf_pkg::CMD_STATUS_WORD:  rsp_data_nxt = {upper_r, lower_r};
      bgsf_pkg::CMD_STATUS:       rsp_data_nxt = {12'h000, err_r};
      bgsf_pkg::CMD_UNCERTAINTY:  rsp_data_nxt = uncert_r;
      default:                    rsp_data_nxt = 16'h0000;
    endcase
  end

  // ************************************************************
  // Answer path
  // ************************************************************
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 16'h0000;
    end
    else
    begin
      rsp_valid_r <= rd_req;
      if (rd_req)
        rsp_data_r <= rsp_data_nxt;
    end
  end

  // Errors; a locked write is dropped silently, not flagged
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      err_r <= bgsf_pkg::ERR_OK;
    else if (wr_ok)
    begin
      case (cmd_i.code)
        bgsf_pkg::CMD_UNCERTAINTY,
        bgsf_pkg::CMD_RESET_TRIGGER: err_r <= bgsf_pkg::ERR_OK;
        bgsf_pkg::CMD_CHEM_STRING,
        bgsf_pkg::CMD_MAKER_DATA,
        bgsf_pkg::CMD_STATUS,
        bgsf_pkg::CMD_STATUS_WORD,
        bgsf_pkg::CMD_FIRST_CUTOFF,
        bgsf_pkg::CMD_FINAL_CUTOFF:  err_r <= bgsf_pkg::ERR_ACCESS_DENIED;
        default:                     err_r <= bgsf_pkg::ERR_UNSUPPORTED;
      endcase
    end
    else if (rd_req && cmd_i.code != bgsf_pkg::CMD_STATUS)
      err_r <= bgsf_pkg::ERR_OK;
    else if (rd_req)
      err_r <= bgsf_pkg::ERR_OK;
  end

  // ************************************************************
  // Writable words and software reset
  // ************************************************************
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      uncert_r <= bgsf_pkg::UNCERT_RESET;
    else if (reset_hit)
      uncert_r <= bgsf_pkg::UNCERT_RESET;
    else if (wr_ok && cmd_i.code == bgsf_pkg::CMD_UNCERTAINTY)
      uncert_r <= cmd_i.wdata;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      sw_reset_r <= 1'b0;
    else
      sw_reset_r <= reset_hit;
  end

  // EEPROM defaults; reload is requested by sw_reset_o
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      first_cutoff_r <= 16'h0000;
      final_cutoff_r <= 16'h0000;
      chem_str_r     <= '0;
      maker_r        <= '0;
    end
    else if (cfg_load_i)
    begin
      first_cutoff_r <= cfg_i.first_cutoff;
      final_cutoff_r <= cfg_i.final_cutoff;
      chem_str_r     <= cfg_i.chem_str;
      maker_r        <= cfg_i.maker_data;
    end
  end

  // ************************************************************
  // Upper status byte
  // ************************************************************
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      upper_r <= 8'h00;
    else if (reset_hit)
      upper_r <= 8'h00;
    else
    begin
      if (cfg_load_i)
      begin
        upper_r[bgsf_pkg::UB_DISPLAY] <= cfg_i.display_select;
        upper_r[bgsf_pkg::UB_CHEM]    <= cfg_i.chemistry_select;
        upper_r[bgsf_pkg::UB_CC]      <= cfg_i.charge_termination_preset;
      end
      // Set wins over clear so a fresh event is never lost
      if (meas_i.v_high)
        upper_r[bgsf_pkg::UB_HIGH_V] <= 1'b1;
      else if (meas_i.v_low)
        upper_r[bgsf_pkg::UB_HIGH_V] <= 1'b0;
      if (meas_i.temp_below0)
        upper_r[bgsf_pkg::UB_COLD] <= 1'b1;
      else if (meas_i.temp_above5)
        upper_r[bgsf_pkg::UB_COLD] <= 1'b0;
      if (meas_i.cur_over)
        upper_r[bgsf_pkg::UB_OVERCUR] <= 1'b1;
      else if (meas_i.cur_below256)
        upper_r[bgsf_pkg::UB_OVERCUR] <= 1'b0;
      upper_r[bgsf_pkg::UB_RSVD_HI] <= 1'b0;
      upper_r[bgsf_pkg::UB_RSVD_LO] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rm_load_r <= 1'b0;
    else
      rm_load_r <= meas_i.valid_term && upper_r[bgsf_pkg::UB_CC];
  end

  // ************************************************************
  // Lower status byte
  // ************************************************************
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      lower_r <= 8'h00;
    else if (reset_hit)
      lower_r <= 8'h00;
    else
    begin
      if (cfg_load_i)
        lower_r[bgsf_pkg::LB_LOCK] <= cfg_i.write_lock_bit;
      if (meas_i.charge_sense && meas_i.charge_10mah)
        lower_r[bgsf_pkg::LB_VQ] <= 1'b1;
      else if (meas_i.discharging || !meas_i.charge_sense)
        lower_r[bgsf_pkg::LB_VQ] <= 1'b0;
      if (meas_i.learn_start)
        lower_r[bgsf_pkg::LB_LEARN] <= 1'b1;
      else if (meas_i.partial_charge || meas_i.self_dis_over
               || (meas_i.below_first && meas_i.temp_below0))
        lower_r[bgsf_pkg::LB_LEARN] <= 1'b0;
      if (meas_i.drain_over)
        lower_r[bgsf_pkg::LB_DRAIN] <= 1'b1;
      else if (meas_i.drain_under)
        lower_r[bgsf_pkg::LB_DRAIN] <= 1'b0;
      if (meas_i.below_first && !lower_r[bgsf_pkg::LB_DRAIN])
        lower_r[bgsf_pkg::LB_FIRST] <= 1'b1;
      else if (lower_r[bgsf_pkg::LB_VQ] && meas_i.above_first)
        lower_r[bgsf_pkg::LB_FIRST] <= 1'b0;
      if (meas_i.below_final && !lower_r[bgsf_pkg::LB_DRAIN])
        lower_r[bgsf_pkg::LB_FINAL] <= 1'b1;
      else if (lower_r[bgsf_pkg::LB_VQ] && meas_i.above_final)
        lower_r[bgsf_pkg::LB_FINAL] <= 1'b0;
      lower_r[bgsf_pkg::LB_RSVD_HI] <= 1'b0;
      lower_r[bgsf_pkg::LB_RSVD_LO] <= 1'b0;
    end
  end

  assign rsp_valid_o      = rsp_valid_r;
  assign rsp_data_o       = rsp_data_r;
  assign err_code_o       = err_r;
  assign status_word_o    = {upper_r, lower_r};
  assign display_select_o = upper_r[bgsf_pkg::UB_DISPLAY];
  assign rm_load_o        = rm_load_r;
  assign sw_reset_o       = sw_reset_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_key_write;
    wr_req && !lower_r[bgsf_pkg::LB_LOCK] && cmd_i.code == bgsf_pkg::CMD_RESET_TRIGGER
    && cmd_i.wdata == bgsf_pkg::RESET_KEY && uncert_r != bgsf_pkg::UNCERT_BLOCKED;
  endsequence

  sequence s_reset_done;
    sw_reset_o && status_word_o == 16'h0000;
  endsequence

  property p_sw_reset;
    @(posedge mclk_i) disable iff (rst_i) s_key_write |=> s_reset_done;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("Key write gave no reset");

  property p_no_reset_locked;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_req && lower_r[bgsf_pkg::LB_LOCK]) |=> !sw_reset_o && $stable(uncert_r);
  endproperty
  a_no_reset_locked: assert property (p_no_reset_locked) else $error("Locked write acted");

  property p_ro_denied;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_ok && cmd_i.code == bgsf_pkg::CMD_STATUS_WORD)
      |=> err_code_o == bgsf_pkg::ERR_ACCESS_DENIED;
  endproperty
  a_ro_denied: assert property (p_ro_denied) else $error("Read-only write not denied");

  property p_read_clears;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_req && !wr_req) |=> err_code_o == bgsf_pkg::ERR_OK;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Read left error code");

  property p_word_read;
    @(posedge mclk_i) disable iff (rst_i)
      (rd_req && cmd_i.code == bgsf_pkg::CMD_STATUS_WORD)
      |=> rsp_valid_o && rsp_data_o == $past(status_word_o);
  endproperty
  a_word_read: assert property (p_word_read) else $error("Status word read wrong");

  property p_cold_hold;
    @(posedge mclk_i) disable iff (rst_i || reset_hit)
      (upper_r[bgsf_pkg::UB_COLD] && !meas_i.temp_above5) |=> upper_r[bgsf_pkg::UB_COLD];
  endproperty
  a_cold_hold: assert property (p_cold_hold) else $error("Cold flag dropped early");

  property p_rm_load;
    @(posedge mclk_i) disable iff (rst_i)
      rm_load_o |-> $past(meas_i.valid_term) && $past(upper_r[bgsf_pkg::UB_CC]);
  endproperty
  a_rm_load: assert property (p_rm_load) else $error("Charge load without preset");

  property p_reserved;
    @(posedge mclk_i) disable iff (rst_i)
      ##1 (status_word_o[14] == 1'b0 && status_word_o[11] == 1'b0
           && status_word_o[7:6] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set");

  property p_first_set;
    @(posedge mclk_i) disable iff (rst_i || reset_hit)
      (meas_i.below_first && !lower_r[bgsf_pkg::LB_DRAIN]) |=> lower_r[bgsf_pkg::LB_FIRST];
  endproperty
  a_first_set: assert property (p_first_set) else $error("First cutoff not set");

  property p_final_set;
    @(posedge mclk_i) disable iff (rst_i || reset_hit)
      (meas_i.below_final && !lower_r[bgsf_pkg::LB_DRAIN]) |=> lower_r[bgsf_pkg::LB_FINAL];
  endproperty
  a_final_set: assert property (p_final_set) else $error("Final cutoff not set");

  property p_drain;
    @(posedge mclk_i) disable iff (rst_i || reset_hit)
      meas_i.drain_over |=> lower_r[bgsf_pkg::LB_DRAIN];
  endproperty
  a_drain: assert property (p_drain) else $error("High drain flag not set");

endmodule : bgsf_top

// ===== dv/bgsf_host_model.sv
// Host model: issues commands on the decoded port and reloads defaults on request.
// Assumes the device samples cmd_o on the rising edge of mclk_i.
`timescale 1ns/1ps
module bgsf_host_model
(
  input  wire logic          mclk_i,
  input  wire logic          sw_reset_i,
  input  wire logic          rsp_valid_i,
  input  wire logic [15:0]   rsp_data_i,
  output bgsf_pkg::bgsf_cmd_t cmd_o,
  output bgsf_pkg::bgsf_cfg_t cfg_o,
  output logic               cfg_load_o
);
  int reload_wait = 0;

  initial
  begin
    cmd_o      = '0;
    cfg_o      = '0;
    cfg_load_o = 1'b0;
  end

  // ************************************************************
  // Command transfers
  // ************************************************************
  // Released fields are inverted so stale values never look valid
  task automatic send(input logic w, input logic [7:0] c, input logic [3:0] ix,
                      input logic [15:0] d, output logic rv, output logic [15:0] rd);
    @(negedge mclk_i);
    cmd_o = '{1'b1, w, c, ix, d};
    @(negedge mclk_i);
    cmd_o = '{1'b0, ~w, ~c, ~ix, ~d};
    rv = rsp_valid_i;
    rd = rsp_data_i;
  endtask : send

  // Uncertainty then key, back to back
  task automatic soft_reset(input logic [15:0] unc);
    @(negedge mclk_i);
    cmd_o = '{1'b1, 1'b1, bgsf_pkg::CMD_UNCERTAINTY, 4'h0, unc};
    @(negedge mclk_i);
    cmd_o = '{1'b1, 1'b1, bgsf_pkg::CMD_RESET_TRIGGER, 4'h0, bgsf_pkg::RESET_KEY};
    @(negedge mclk_i);
    cmd_o = '{1'b0, 1'b0, 8'hFF, 4'hF, ~bgsf_pkg::RESET_KEY};
  endtask : soft_reset

  // ************************************************************
  // Defaults, including the assembly-time lock
  // ************************************************************
  task automatic load(input bgsf_pkg::bgsf_cfg_t c);
    @(negedge mclk_i);
    cfg_o      = c;
    cfg_load_o = 1'b1;
    @(negedge mclk_i);
    cfg_load_o = 1'b0;
  endtask : load

  // Reload answers prompt or slow, as reload_wait says
  always @(posedge mclk_i)
    if (sw_reset_i)
    begin
      repeat (reload_wait + 1) @(negedge mclk_i);
      cfg_load_o = 1'b1;
      @(negedge mclk_i);
      cfg_load_o = 1'b0;
    end
endmodule : bgsf_host_model

// ===== dv/battery_gauge_status_flags_tb_top.sv
// Self-checking bench for the gauge status and identity registers.
// Assumes bgsf_top and the host model; meas_i is driven here at random.
`timescale 1ns/1ps
`define CHK(act, exp) \
  begin \
    samples_checked++; \
    if ((act) !== (exp)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
  end
module battery_gauge_status_flags_tb_top;
  logic                 mclk_i = 1'b0;
  logic                 rst_i = 1'b1;
  bgsf_pkg::bgsf_cmd_t  cmd;
  bgsf_pkg::bgsf_meas_t meas;
  bgsf_pkg::bgsf_cfg_t  cfg, cfg_v;
  logic                 cfg_load, rsp_valid, disp, rm_load, sw_reset;
  logic [15:0]          rsp_data, status_word, dyn, last_d;
  logic [3:0]           err_code;
  logic                 last_v, exp_rm;
  logic [319:0]         pool;
  int                   seed = 66036;
  int                   err_total = 0;
  int                   samples_checked = 0;
  int                   k;
  logic [7:0]           ro_codes [6] = '{8'h16, 8'h22, 8'h23, 8'h2F, 8'h3E, 8'h3F};

  always #5 mclk_i = ~mclk_i;

  bgsf_top bgsf_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_i(cmd), .meas_i(meas),
    .cfg_i(cfg), .cfg_load_i(cfg_load), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .err_code_o(err_code), .status_word_o(status_word), .display_select_o(disp),
    .rm_load_o(rm_load), .sw_reset_o(sw_reset));

  bgsf_host_model bgsf_host_model_i (.mclk_i(mclk_i), .sw_reset_i(sw_reset),
    .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .cmd_o(cmd), .cfg_o(cfg),
    .cfg_load_o(cfg_load));

  // ************************************************************
  // Expectations
  // ************************************************************
  // Dynamic flags; set beats clear, cutoffs use the old drain and charge bits
  function automatic logic [15:0] nxt(input logic [15:0] d, input bgsf_pkg::bgsf_meas_t m);
    logic [15:0] n;
    n     = d;
    n[10] = m.v_high ? 1'b1 : (m.v_low ? 1'b0 : d[10]);
    n[9]  = m.temp_below0 ? 1'b1 : (m.temp_above5 ? 1'b0 : d[9]);
    n[8]  = m.cur_over ? 1'b1 : (m.cur_below256 ? 1'b0 : d[8]);
    n[5]  = (m.charge_sense && m.charge_10mah) ? 1'b1 :
            ((m.discharging || !m.charge_sense) ? 1'b0 : d[5]);
    n[3]  = m.learn_start ? 1'b1 : ((m.partial_charge || m.self_dis_over ||
            (m.below_first && m.temp_below0)) ? 1'b0 : d[3]);
    n[2]  = m.drain_over ? 1'b1 : (m.drain_under ? 1'b0 : d[2]);
    n[1]  = (m.below_first && !d[2]) ? 1'b1 : ((d[5] && m.above_first) ? 1'b0 : d[1]);
    n[0]  = (m.below_final && !d[2]) ? 1'b1 : ((d[5] && m.above_final) ? 1'b0 : d[0]);
    return n;
  endfunction : nxt

  function automatic logic [15:0] ew();
    return {cfg_v.display_select, 1'b0, cfg_v.chemistry_select,
            cfg_v.charge_termination_preset, 1'b0, dyn[10:8], 2'b00, dyn[5],
            cfg_v.write_lock_bit, dyn[3:0]};
  endfunction : ew

  // ************************************************************
  // Bench tasks
  // ************************************************************
  task automatic rd(input logic [7:0] c, input logic [3:0] ix);
    bgsf_host_model_i.send(1'b0, c, ix, 16'h0000, last_v, last_d);
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    bgsf_host_model_i.send(1'b1, c, 4'h0, d, last_v, last_d);
  endtask : wr

  task automatic new_cfg(input logic lk);
    pool = '0;
    for (k = 0; k < 10; k++)
      pool = {pool[287:0], $random(seed)};
    cfg_v                  = pool[291:0];
    cfg_v.chem_str[7:4]    = 4'h0;
    cfg_v.maker_data[7:4]  = 4'h0;
    cfg_v.write_lock_bit   = lk;
    bgsf_host_model_i.load(cfg_v);
    `CHK(disp, cfg_v.display_select)
  endtask : new_cfg

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    meas = '0;
    dyn  = '0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    new_cfg(1'b0);
    `CHK(status_word, ew())
    // Random comparator traffic; only sampled edges matter
    for (int n = 0; n < 400; n++)
    begin
      meas   = 19'($random(seed));
      exp_rm = meas.valid_term & cfg_v.charge_termination_preset;
      @(negedge mclk_i);
      dyn = nxt(dyn, meas);
      `CHK(status_word, ew())
      `CHK(rm_load, exp_rm)
      `CHK(status_word[1:0], dyn[1:0])
    end
    meas = '0;
    rd(bgsf_pkg::CMD_STATUS_WORD, 4'h0);
    `CHK({last_v, last_d}, {1'b1, ew()})
    for (int i = 0; i < 16; i++)
    begin
      rd(bgsf_pkg::CMD_CHEM_STRING, i[3:0]);
      `CHK({last_v, last_d}, {9'h100, cfg_v.chem_str[8*i+:8]})
      rd(bgsf_pkg::CMD_MAKER_DATA, i[3:0]);
      `CHK({last_v, last_d}, {9'h100, cfg_v.maker_data[8*i+:8]})
    end
    rd(bgsf_pkg::CMD_FIRST_CUTOFF, 4'h0);
    `CHK({last_v, last_d}, {1'b1, cfg_v.first_cutoff})
    rd(bgsf_pkg::CMD_FINAL_CUTOFF, 4'h0);
    `CHK({last_v, last_d}, {1'b1, cfg_v.final_cutoff})
    // Every read-only code refuses a write; the next read clears the code
    for (int i = 0; i < 6; i++)
    begin
      wr(ro_codes[i], 16'($random(seed)));
      `CHK(err_code, bgsf_pkg::ERR_ACCESS_DENIED)
      rd(bgsf_pkg::CMD_STATUS, 4'h0);
      `CHK({last_d[3:0], err_code}, {bgsf_pkg::ERR_ACCESS_DENIED, bgsf_pkg::ERR_OK})
    end
    wr(8'h55, 16'h1234);
    `CHK(err_code, bgsf_pkg::ERR_UNSUPPORTED)
    rd(bgsf_pkg::CMD_FIRST_CUTOFF, 4'h0);
    `CHK(err_code, bgsf_pkg::ERR_OK)
    // Locked: writes vanish silently, key has no effect
    new_cfg(1'b1);
    wr(bgsf_pkg::CMD_CHEM_STRING, 16'h00FF);
    `CHK(err_code, bgsf_pkg::ERR_OK)
    bgsf_host_model_i.soft_reset(16'h0005);
    `CHK(sw_reset, 1'b0)
    rd(bgsf_pkg::CMD_STATUS_WORD, 4'h0);
    `CHK({last_v, last_d}, {1'b1, ew()})
    new_cfg(1'b0);
    bgsf_host_model_i.soft_reset(bgsf_pkg::UNCERT_BLOCKED);
    `CHK(sw_reset, 1'b0)
    rd(bgsf_pkg::CMD_UNCERTAINTY, 4'h0);
    `CHK(last_d, bgsf_pkg::UNCERT_BLOCKED)
    // Unlocked key with a slow reload; flags restart, defaults come back
    bgsf_host_model_i.reload_wait = 3;
    bgsf_host_model_i.soft_reset(16'h0005);
    `CHK({sw_reset, status_word}, {1'b1, 16'h0000})
    dyn = '0;
    // Polled on the rising edge; the model raises the load on the falling one
    for (k = 0; k < 20 && cfg_load !== 1'b1; k++)
      @(posedge mclk_i);
    if (k == 20)
      err_total++;
    else
    begin
      @(negedge mclk_i);
      `CHK(status_word, ew())
      rd(bgsf_pkg::CMD_UNCERTAINTY, 4'h0);
      `CHK(last_d, bgsf_pkg::UNCERT_RESET)
    end
    wrap_up();
  end
endmodule : battery_gauge_status_flags_tb_top
